/* common/ufs_pkg.sv */
// ufs_pkg: constants and types for the user flash block sequencer
// assumes a 200 MHz core clock; all times converted to cycles here
package ufs_pkg;
    // ==========================================
    // clock and timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int BUSY_RISE_MAX_NS = 960;
    localparam int PROG_BUSY_MAX_US = 100;
    localparam int ERASE_BUSY_MAX_MS = 500;
    localparam int OSC_FIRST_EDGE_MIN_NS = 180;
    localparam int READ_ACCESS_MAX_NS = 65;
    localparam int DOUT_DELAY_MAX_NS = 5;
    localparam int BUSY_RISE_CYC = (BUSY_RISE_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int PROG_BUSY_CYC = (PROG_BUSY_MAX_US * 1000000) / CLK_PERIOD_PS;
    localparam longint ERASE_BUSY_CYC = (64'(ERASE_BUSY_MAX_MS) * 64'd1000000000)
        / CLK_PERIOD_PS;
    localparam int OSC_START_CYC = (OSC_FIRST_EDGE_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int READ_CYC = (READ_ACCESS_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int DOUT_CYC_RAW = (DOUT_DELAY_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int DOUT_CYC = (DOUT_CYC_RAW < 1) ? 1 : DOUT_CYC_RAW;
    localparam int OSC_HALF_CYC = 8;
    // ==========================================
    // geometry and reset values
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
    // ==========================================
    // types
    typedef enum logic [4:0] {
        UFS_IDLE  = 5'b00001,
        UFS_DELAY = 5'b00010,
        UFS_PROG  = 5'b00100,
        UFS_ERASE = 5'b01000,
        UFS_DONE  = 5'b10000
    } ufs_state_t;
    typedef struct packed {
        logic program_req;
        logic erase_req;
        logic oscillator_enable;
        logic addr_clk;
        logic addr_shift;
        logic addr_din;
        logic data_clk;
        logic data_shift;
        logic data_din;
    } ufs_pins_t;
endpackage

/* rtl/ufs_mem.sv */
// ufs_mem: flash word array with registered read data
// assumes single clock, one access per cycle
module ufs_mem
    import ufs_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_q [0:(1<<AW)-1];
    logic [DW-1:0] rdata_q;
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[addr_i] <= wdata_i;
        end
        rdata_q <= mem_q[addr_i];
    end
    assign rdata_o = rdata_q;
endmodule

/* rtl/ufs_top.sv */
// ufs_top: user flash block, program/erase/read sequencing and serial regs
// assumes array-side pins are asynchronous and arrive through synchronisers
// Functional notes
// - busy rises within 960 ns after program request rises.
// - program busy pulse lasts at most 100 us.
// - busy rises within 960 ns after erase request rises.
// - erase busy pulse lasts at most 500 ms.
// - oscillator first rising edge no earlier than 180 ns after enable.
// - read data valid within 65 ns access time.
// - serial data output changes within 5 ns of data clock edge; dout_q changes about 22.5 ns after the pin edge, behind the synchronisers.
module ufs_top
    import ufs_pkg::*;
#(
    parameter int PROG_CYC = PROG_BUSY_CYC,
    parameter longint ERASE_CYC = ERASE_BUSY_CYC,
    parameter int PROG_WORK = 2000,
    parameter int ERASE_WORK = 2000
) (
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    input wire logic PROGRAM_I,
    input wire logic ERASE_I,
    input wire logic OSCILLATOR_ENABLE_I,
    input wire logic ADDR_CLK_I,
    input wire logic ADDR_SHIFT_I,
    input wire logic ADDR_DIN_I,
    input wire logic DATA_CLK_I,
    input wire logic DATA_SHIFT_I,
    input wire logic DATA_DIN_I,
    output logic BUSY_O,
    output logic OSC_O,
    output logic DATA_DOUT_O
);
    // ==========================================
    // input synchronisers
    ufs_pins_t pins_in, s1_q, s2_q, s3_q, stab_q, stab_d, prev_q;
    assign pins_in = '{PROGRAM_I, ERASE_I, OSCILLATOR_ENABLE_I, ADDR_CLK_I,
        ADDR_SHIFT_I, ADDR_DIN_I, DATA_CLK_I, DATA_SHIFT_I, DATA_DIN_I};
    always_comb begin
        stab_d = stab_q;
        for (int i = 0; i < $bits(ufs_pins_t); i++) begin
            if (s2_q[i] == s3_q[i]) begin
                stab_d[i] = s3_q[i];
            end
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            stab_q <= '0;
            prev_q <= '0;
        end else begin
            s1_q <= pins_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stab_q <= stab_d;
            prev_q <= stab_q;
        end
    end
    logic prog_rise, erase_rise, aclk_rise, dclk_rise;
    assign prog_rise = stab_q.program_req & ~prev_q.program_req;
    assign erase_rise = stab_q.erase_req & ~prev_q.erase_req;
    assign aclk_rise = stab_q.addr_clk & ~prev_q.addr_clk;
    assign dclk_rise = stab_q.data_clk & ~prev_q.data_clk;
    // ==========================================
    // internal oscillator
    logic [7:0] osc_wait_q, osc_wait_d;
    logic [3:0] osc_div_q, osc_div_d;
    logic osc_q, osc_d, osc_tick;
    always_comb begin
        osc_wait_d = osc_wait_q;
        osc_div_d = osc_div_q;
        osc_d = osc_q;
        osc_tick = 1'b0;
        if (!stab_q.oscillator_enable) begin
            osc_wait_d = '0;
            osc_div_d = '0;
            osc_d = 1'b0;
        end else if (osc_wait_q < 8'(OSC_START_CYC)) begin
            osc_wait_d = osc_wait_q + 8'h01;
        end else if (osc_div_q == 4'(OSC_HALF_CYC - 1)) begin
            osc_div_d = '0;
            osc_d = ~osc_q;
            osc_tick = ~osc_q;
        end else begin
            osc_div_d = osc_div_q + 4'h1;
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            osc_wait_q <= '0;
            osc_div_q <= '0;
            osc_q <= 1'b0;
        end else begin
            osc_wait_q <= osc_wait_d;
            osc_div_q <= osc_div_d;
            osc_q <= osc_d;
        end
    end
    // ==========================================
    // serial address and data registers
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] dreg_q, dreg_d, rdata;
    logic [3:0] rd_cnt_q, rd_cnt_d;
    logic load_q, load_d, dout_q, dout_d, mem_we;
    ufs_state_t st_q, st_d;
    always_comb begin
        addr_d = addr_q;
        dreg_d = dreg_q;
        dout_d = dout_q;
        load_d = 1'b0;
        rd_cnt_d = rd_cnt_q;
        if (aclk_rise && stab_q.addr_shift) begin
            addr_d = {addr_q[ADDR_W-2:0], stab_q.addr_din};
            rd_cnt_d = 4'(READ_CYC);
        end else if (rd_cnt_q != 4'h0) begin
            rd_cnt_d = rd_cnt_q - 4'h1;
            load_d = (rd_cnt_q == 4'h2);
        end
        if (load_q) begin
            dreg_d = rdata;
            dout_d = rdata[DATA_W-1];
        end else if (dclk_rise && stab_q.data_shift) begin
            dreg_d = {dreg_q[DATA_W-2:0], stab_q.data_din};
            dout_d = dreg_q[DATA_W-2];
        end else if (dclk_rise && st_q == UFS_IDLE) begin
            dreg_d = rdata;
            dout_d = rdata[DATA_W-1];
        end
    end
    // ==========================================
    // program and erase sequencer
    logic [31:0] cnt_q, cnt_d;
    logic [ADDR_W:0] wipe_q, wipe_d;
    logic busy_q, busy_d, is_erase_q, is_erase_d;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] mem_wdata;
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        is_erase_d = is_erase_q;
        wipe_d = wipe_q;
        mem_we = 1'b0;
        mem_addr = addr_q;
        mem_wdata = dreg_q;
        case (st_q)
            UFS_IDLE: begin
                cnt_d = '0;
                if (prog_rise || erase_rise) begin
                    is_erase_d = erase_rise & ~prog_rise;
                    st_d = UFS_DELAY;
                end
            end
            UFS_DELAY: begin
                cnt_d = cnt_q + 32'h1;
                if (osc_tick || cnt_q >= 32'(BUSY_RISE_CYC - 8)) begin
                    busy_d = 1'b1;
                    cnt_d = '0;
                    wipe_d = '0;
                    st_d = is_erase_q ? UFS_ERASE : UFS_PROG;
                end
            end
            UFS_PROG: begin
                cnt_d = cnt_q + 32'h1;
                if (cnt_q == 32'h0) begin
                    mem_we = 1'b1;
                end
                if (cnt_q >= 32'(PROG_WORK) || cnt_q >= 32'(PROG_CYC - 1)) begin
                    busy_d = 1'b0;
                    st_d = UFS_DONE;
                end
            end
            UFS_ERASE: begin
                cnt_d = cnt_q + 32'h1;
                if (!wipe_q[ADDR_W]) begin
                    mem_we = 1'b1;
                    mem_addr = wipe_q[ADDR_W-1:0];
                    mem_wdata = ERASED_WORD;
                    wipe_d = wipe_q + 1'b1;
                end
                if (cnt_q >= 32'(ERASE_WORK) || 64'(cnt_q) >= ERASE_CYC - 64'd1) begin
                    busy_d = 1'b0;
                    st_d = UFS_DONE;
                end
            end
            UFS_DONE: begin
                // wait for request to drop
                if (!stab_q.program_req && !stab_q.erase_req) begin
                    st_d = UFS_IDLE;
                end
            end
            default: begin
                st_d = UFS_IDLE;
                busy_d = 1'b0;
            end
        endcase
    end
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            st_q <= UFS_IDLE;
            cnt_q <= '0;
            busy_q <= 1'b0;
            is_erase_q <= 1'b0;
            wipe_q <= '0;
            addr_q <= '0;
            dreg_q <= '0;
            dout_q <= 1'b0;
            load_q <= 1'b0;
            rd_cnt_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            is_erase_q <= is_erase_d;
            wipe_q <= wipe_d;
            addr_q <= addr_d;
            dreg_q <= dreg_d;
            dout_q <= dout_d;
            load_q <= load_d;
            rd_cnt_q <= rd_cnt_d;
        end
    end
    ufs_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
        .clk_i(CLOCK_I),
        .we_i(mem_we),
        .addr_i(mem_addr),
        .wdata_i(mem_wdata),
        .rdata_o(rdata)
    );
    assign BUSY_O = busy_q;
    assign OSC_O = osc_q;
    assign DATA_DOUT_O = dout_q;
endmodule

/* bench/ufs_top_assertions.sv */
// ufs_top_assertions: pin timing checks for the flash block
// assumes bound into ufs_top, one core clock domain
module ufs_top_chk
    import ufs_pkg::*;
#(
    parameter int PROG_CYC = PROG_BUSY_CYC,
    parameter longint ERASE_CYC = ERASE_BUSY_CYC
) (
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    input wire logic PROGRAM_I,
    input wire logic ERASE_I,
    input wire logic OSCILLATOR_ENABLE_I,
    input wire logic DATA_CLK_I,
    input wire logic DATA_SHIFT_I,
    input wire logic BUSY_O,
    input wire logic OSC_O,
    input wire logic DATA_DOUT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RISE_MAX = BUSY_RISE_CYC;
    logic [31:0] busy_cnt_q;
    logic [31:0] en_cnt_q;
    logic [7:0] age_q;
    logic dclk_q;
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);
    // ==========================================
    // helper counters
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            busy_cnt_q <= 32'h0;
            en_cnt_q <= 32'h0;
            age_q <= 8'hff;
        end else begin
            busy_cnt_q <= BUSY_O ? busy_cnt_q + 32'h1 : 32'h0;
            en_cnt_q <= OSCILLATOR_ENABLE_I ? en_cnt_q + 32'h1 : 32'h0;
            age_q <= (DATA_CLK_I && !dclk_q) ? 8'h0 : age_q + 8'(age_q != 8'hff);
        end
        dclk_q <= DATA_CLK_I;
    end
    // ==========================================
    // properties
    property p_prog_rise;
        $rose(PROGRAM_I) && !ERASE_I && !BUSY_O |-> ##[1:RISE_MAX] BUSY_O;
    endproperty
    a_prog_rise: assert property (p_prog_rise) else $error("busy late after program");
    property p_prog_len;
        BUSY_O && PROGRAM_I |-> busy_cnt_q < 32'(PROG_CYC);
    endproperty
    a_prog_len: assert property (p_prog_len) else $error("program busy too long");
    property p_erase_rise;
        $rose(ERASE_I) && !PROGRAM_I && !BUSY_O |-> ##[1:RISE_MAX] BUSY_O;
    endproperty
    a_erase_rise: assert property (p_erase_rise) else $error("busy late after erase");
    property p_erase_len;
        BUSY_O && ERASE_I |-> 64'(busy_cnt_q) < ERASE_CYC;
    endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase busy too long");
    property p_osc_first;
        $rose(OSC_O) |-> en_cnt_q >= 32'(OSC_START_CYC);
    endproperty
    a_osc_first: assert property (p_osc_first) else $error("oscillator edge early");
    property p_osc_off;
        !OSCILLATOR_ENABLE_I [*8] |-> !OSC_O;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator runs disabled");
    property p_dout_delay;
        $changed(DATA_DOUT_O) && DATA_SHIFT_I && !BUSY_O |-> age_q <= 8'h7;
    endproperty
    a_dout_delay: assert property (p_dout_delay) else $error("serial out late");
endmodule

bind ufs_top ufs_top_chk #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) i_chk (
    .CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .PROGRAM_I(PROGRAM_I), .ERASE_I(ERASE_I),
    .OSCILLATOR_ENABLE_I(OSCILLATOR_ENABLE_I), .DATA_CLK_I(DATA_CLK_I),
    .DATA_SHIFT_I(DATA_SHIFT_I), .BUSY_O(BUSY_O), .OSC_O(OSC_O), .DATA_DOUT_O(DATA_DOUT_O));

/* bench/ufs_user.sv */
// ufs_user: array-side user logic driving the flash block pins
// assumes pins change at the falling core clock edge
module ufs_user
    import ufs_pkg::*;
(
    input wire logic clk_i,
    input wire logic busy_i,
    input wire logic dout_i,
    output ufs_pins_t pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins_o = '0;
    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // program or erase cycle, returns cycles to busy and busy length
    task automatic op(input logic erase, output int rise, output int blen);
        pins_o.oscillator_enable = 1'b1;
        w(52);
        if (erase) pins_o.erase_req = 1'b1;
        else pins_o.program_req = 1'b1;
        for (rise = 0; !busy_i && rise < 400; rise++) w(1);
        for (blen = 0; busy_i && blen < 5000; blen++) w(1);
        w(5);
        pins_o.program_req = 1'b0;
        pins_o.erase_req = 1'b0;
        w(52);
        pins_o.oscillator_enable = 1'b0;
    endtask
    // one bit on a 20-cycle register clock
    task automatic bit_out(input logic dat, input logic b, output logic s);
        if (dat) pins_o.data_din = b;
        else pins_o.addr_din = b;
        w(4);
        if (dat) pins_o.data_clk = 1'b1;
        else pins_o.addr_clk = 1'b1;
        w(7);
        s = dout_i;
        w(3);
        pins_o.data_clk = 1'b0;
        pins_o.addr_clk = 1'b0;
        w(6);
    endtask
    // address in, then word exchange through the data register
    task automatic xfer(input logic [8:0] a, input logic [15:0] wd,
        output logic [15:0] rd, output logic last);
        logic s;
        pins_o.addr_shift = 1'b1;
        for (int i = 8; i >= 0; i--) bit_out(1'b0, a[i], s);
        pins_o.addr_shift = 1'b0;
        pins_o.addr_din = ~a[0];
        w(20);
        pins_o.data_shift = 1'b1;
        w(12);
        rd[15] = dout_i;
        for (int i = 15; i >= 0; i--) begin
            bit_out(1'b1, wd[i], s);
            if (i > 0) rd[i-1] = s;
            else last = s;
        end
        w(4);
        pins_o.data_shift = 1'b0;
        pins_o.data_din = ~wd[0];
    endtask
endmodule

/* bench/testbench.sv */
// testbench: erase, program and read sequences with random words
// assumes ufs_user drives the array side, checker bound to ufs_top
module testbench
    import ufs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    ufs_pins_t pins;
    logic busy, osc, dout, last;
    logic [15:0] d, rd;
    logic [8:0] a;
    int bad_count = 0, total_checks = 0, seed = 26, cyc = 0, rise, blen;
    // caps below the work counts, so the busy limits themselves end each pulse
    localparam int PROG_LIM = 600;
    localparam longint ERASE_LIM = 700;
    always #2.5 clk = ~clk;
    ufs_top #(.PROG_CYC(PROG_LIM), .ERASE_CYC(ERASE_LIM), .PROG_WORK(800),
        .ERASE_WORK(900)) i_dut (
        .CLOCK_I(clk), .SRST_I(srst), .PROGRAM_I(pins.program_req), .ERASE_I(pins.erase_req),
        .OSCILLATOR_ENABLE_I(pins.oscillator_enable), .ADDR_CLK_I(pins.addr_clk),
        .ADDR_SHIFT_I(pins.addr_shift), .ADDR_DIN_I(pins.addr_din), .DATA_CLK_I(pins.data_clk),
        .DATA_SHIFT_I(pins.data_shift), .DATA_DIN_I(pins.data_din), .BUSY_O(busy), .OSC_O(osc),
        .DATA_DOUT_O(dout));
    ufs_user i_user (.clk_i(clk), .busy_i(busy), .dout_i(dout), .pins_o(pins));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            stop_test();
        end
    end
    // ==========================================
    // oscillator start monitor
    int en_age = 0;
    logic osc_seen = 1'b0;
    always @(negedge clk) begin
        en_age = pins.oscillator_enable ? en_age + 1 : 0;
        if (osc && !osc_seen) begin
            check(32'(en_age > OSC_START_CYC), 32'h1);
        end
        osc_seen = osc;
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        check({29'h0, busy, osc, dout}, 32'h0);
        i_user.op(1'b1, rise, blen);
        check(32'(rise <= 192), 32'h1);
        check(32'(blen > 0 && blen <= ERASE_LIM), 32'h1);
        i_user.xfer(9'h1ff, 16'h0, rd, last);
        check(rd, 16'hffff);
        for (int i = 0; i < 4; i++) begin
            a = {i[1:0], 7'($random(seed))};
            d = 16'($random(seed));
            if (i == 0) a = 9'h0;
            i_user.xfer(a, d, rd, last);
            check(rd, 16'hffff);
            check(last, d[15]);
            i_user.op(1'b0, rise, blen);
            check(32'(rise <= 192), 32'h1);
            check(32'(blen > 0 && blen <= PROG_LIM), 32'h1);
            i_user.xfer(a, ~d, rd, last);
            check(rd, d);
        end
        stop_test();
    end
endmodule
